//--- src/t2crb_top.sv
// Sixteen-bit timer/counter with autoreload, capture and baud-rate modes.
// Assumes one 100 MHz clock, a synchronous reset and asynchronous pins.
`timescale 1ns/1ns
`default_nettype none
`include "t2crb_defs.svh"

// Notes on behaviour
// - Overflow sets overflow flag except when a serial clock select is set.
// - Enabled trigger falling edge causing capture or reload sets edge flag.
// - Receive clock select routes overflow pulses to the serial receiver.
// - Transmit clock select routes overflow pulses to the serial transmitter.
// - Trigger enable lets trigger falls capture or reload unless timer clocks serial port.
// - Run control starts and stops counting; cleared means timer off.
// - Source select picks count pin falls or divided core clock ticks.
// - Capture select picks capture or reload; ignored in baud-rate mode.
// - Either serial select gives baud mode, else capture select decides.
// - Autoreload: rollover sets overflow flag and loads the reload word.
// - Autoreload with trigger enable: trigger fall also reloads, sets flag.
// - Capture mode without trigger enable is a plain overflowing counter.
// - Capture mode with trigger enable: trigger fall copies count, sets flag.
// - Overflow and edge flags both can raise the interrupt.
// - Baud mode gives no overflow interrupt; edge interrupt still works.
// - Control register reads zero after reset; timer stopped, flags clear.
module t2crb_top
    import t2crb_pkg::*;
#(
    parameter int unsigned CLK_DIV = `T2CRB_CLK_DIV
) (
    input  wire logic           ref_clk,
    input  wire logic           rst,
    input  wire t2crb_bus_req_t bus_req,
    output var  logic [7:0]     rd_data_q,
    input  wire logic           count_pin,
    input  wire logic           trigger_pin,
    output var  logic           baud_ovf_q,
    output var  logic           rx_clock_sel_q,
    output var  logic           tx_clock_sel_q,
    output var  logic           irq_q
);

    generate
        if (CLK_DIV < 1 || CLK_DIV > 65536) begin : g_bad_div
            $error("CLK_DIV must lie between 1 and 65536.");
        end
    endgenerate

    localparam logic [15:0] DIV_LAST = 16'(CLK_DIV - 1);

    function automatic logic wr_hit(input t2crb_bus_req_t req,
                                    input logic [7:0] where);
        wr_hit = req.wr && (req.addr == where);
    endfunction : wr_hit

    // Pin synchronisers and edge detectors.
    logic [1:0] cnt_sync_q;
    logic [1:0] cnt_sync_d;
    logic       cnt_prev_q;
    logic       cnt_prev_d;
    logic [1:0] trg_sync_q;
    logic [1:0] trg_sync_d;
    logic       trg_prev_q;
    logic       trg_prev_d;
    logic       cnt_fall;
    logic       trg_fall;

    always_comb begin
        cnt_sync_d = {cnt_sync_q[0], count_pin};
        trg_sync_d = {trg_sync_q[0], trigger_pin};
        cnt_prev_d = cnt_sync_q[1];
        trg_prev_d = trg_sync_q[1];
        cnt_fall   = cnt_prev_q && !cnt_sync_q[1];
        trg_fall   = trg_prev_q && !trg_sync_q[1];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_sync_q <= `T2CRB_SYNC_IDLE;
            trg_sync_q <= `T2CRB_SYNC_IDLE;
            cnt_prev_q <= 1'b1;
            trg_prev_q <= 1'b1;
        end else begin
            cnt_sync_q <= cnt_sync_d;
            trg_sync_q <= trg_sync_d;
            cnt_prev_q <= cnt_prev_d;
            trg_prev_q <= trg_prev_d;
        end
    end

    // Core clock tick divider.
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic        div_tick;

    always_comb begin
        div_tick = (div_q == DIV_LAST);
        div_d    = div_tick ? 16'h0000 : div_q + 16'h0001;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_d;
        end
    end

    // Timer state: control, count, reload word, interrupt registers.
    t2crb_ctrl_t ctrl_q;
    t2crb_ctrl_t ctrl_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] rcap_q;
    logic [15:0] rcap_d;
    t2crb_irq_t  stat_q;
    t2crb_irq_t  stat_d;
    t2crb_irq_t  en_q;
    t2crb_irq_t  en_d;
    t2crb_irq_t  clr;
    logic        irq_d;
    logic        baud_ovf_d;
    logic        baud_mode;
    logic        cnt_step;
    logic        ovf_evt;
    logic        trig_evt;
    logic        trig_reload;
    logic        trig_capture;
    logic        ovf_reload;

    always_comb begin
        baud_mode    = ctrl_q.rx_clock_select || ctrl_q.tx_clock_select;
        cnt_step     = ctrl_q.run_control &&
                       (ctrl_q.count_source_select ? cnt_fall : div_tick);
        ovf_evt      = cnt_step && (count_q == `T2CRB_WORD_MAX);
        trig_evt     = trg_fall && ctrl_q.trigger_enable;
        trig_reload  = trig_evt && !baud_mode && !ctrl_q.capture_select;
        trig_capture = trig_evt && !baud_mode && ctrl_q.capture_select;
        ovf_reload   = ovf_evt && (baud_mode || !ctrl_q.capture_select);

        count_d = count_q;
        if (cnt_step) begin
            count_d = count_q + `T2CRB_WORD_ONE;
        end
        if (ovf_reload || trig_reload) begin
            count_d = rcap_q;
        end
        if (wr_hit(bus_req, `T2CRB_ADDR_CNT_LO)) begin
            count_d[7:0] = bus_req.wdata;
        end
        if (wr_hit(bus_req, `T2CRB_ADDR_CNT_HI)) begin
            count_d[15:8] = bus_req.wdata;
        end

        rcap_d = rcap_q;
        if (wr_hit(bus_req, `T2CRB_ADDR_RCAP_LO)) begin
            rcap_d[7:0] = bus_req.wdata;
        end
        if (wr_hit(bus_req, `T2CRB_ADDR_RCAP_HI)) begin
            rcap_d[15:8] = bus_req.wdata;
        end
        if (trig_capture) begin
            rcap_d = count_q;
        end

        ctrl_d = ctrl_q;
        if (wr_hit(bus_req, `T2CRB_ADDR_CTRL)) begin
            ctrl_d = t2crb_ctrl_t'(bus_req.wdata);
        end
        if (ovf_evt && !baud_mode) begin
            ctrl_d.overflow_flag = 1'b1;
        end
        if (trig_evt) begin
            ctrl_d.external_edge_flag = 1'b1;
        end

        clr = '0;
        if (wr_hit(bus_req, `T2CRB_ADDR_IRQ_CLR)) begin
            clr = t2crb_irq_t'(bus_req.wdata[1:0]);
        end
        stat_d          = stat_q & ~clr;
        stat_d.overflow = stat_d.overflow || (ovf_evt && !baud_mode);
        stat_d.ext_edge = stat_d.ext_edge || trig_evt;

        en_d = en_q;
        if (wr_hit(bus_req, `T2CRB_ADDR_IRQ_EN)) begin
            en_d = t2crb_irq_t'(bus_req.wdata[1:0]);
        end
        irq_d      = |(stat_d & en_d);
        baud_ovf_d = ovf_evt && baud_mode;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q         <= t2crb_ctrl_t'(`T2CRB_CTRL_RESET);
            count_q        <= `T2CRB_WORD_RESET;
            rcap_q         <= `T2CRB_WORD_RESET;
            stat_q         <= t2crb_irq_t'(`T2CRB_IRQ_RESET);
            en_q           <= t2crb_irq_t'(`T2CRB_IRQ_RESET);
            irq_q          <= 1'b0;
            baud_ovf_q     <= 1'b0;
            rx_clock_sel_q <= 1'b0;
            tx_clock_sel_q <= 1'b0;
        end else begin
            ctrl_q         <= ctrl_d;
            count_q        <= count_d;
            rcap_q         <= rcap_d;
            stat_q         <= stat_d;
            en_q           <= en_d;
            irq_q          <= irq_d;
            baud_ovf_q     <= baud_ovf_d;
            rx_clock_sel_q <= ctrl_d.rx_clock_select;
            tx_clock_sel_q <= ctrl_d.tx_clock_select;
        end
    end

    // Read data stand in the cycle after the read strobe only.
    logic [7:0] rd_data_d;

    always_comb begin
        rd_data_d = `T2CRB_BYTE_ZERO;
        if (bus_req.rd) begin
            case (bus_req.addr)
                `T2CRB_ADDR_CTRL:     rd_data_d = ctrl_q;
                `T2CRB_ADDR_RCAP_LO:  rd_data_d = rcap_q[7:0];
                `T2CRB_ADDR_RCAP_HI:  rd_data_d = rcap_q[15:8];
                `T2CRB_ADDR_CNT_LO:   rd_data_d = count_q[7:0];
                `T2CRB_ADDR_CNT_HI:   rd_data_d = count_q[15:8];
                `T2CRB_ADDR_IRQ_STAT: rd_data_d = {6'h00, stat_q};
                `T2CRB_ADDR_IRQ_EN:   rd_data_d = {6'h00, en_q};
                default:              rd_data_d = `T2CRB_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data_q <= `T2CRB_BYTE_ZERO;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    // Checks on the timer behaviour.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic no_cnt_wr;
    assign no_cnt_wr = !wr_hit(bus_req, `T2CRB_ADDR_CNT_LO) &&
                       !wr_hit(bus_req, `T2CRB_ADDR_CNT_HI);

    logic no_rcap_wr;
    assign no_rcap_wr = !wr_hit(bus_req, `T2CRB_ADDR_RCAP_LO) &&
                        !wr_hit(bus_req, `T2CRB_ADDR_RCAP_HI);

    logic no_ctrl_wr;
    assign no_ctrl_wr = !wr_hit(bus_req, `T2CRB_ADDR_CTRL);

    sequence s_count_fall;
        cnt_sync_q[1] ##1 !cnt_sync_q[1];
    endsequence

    sequence s_trig_fall_enabled;
        trg_sync_q[1] ##1 (!trg_sync_q[1] && ctrl_q.trigger_enable);
    endsequence

    a_ovf_flag_set: assert property (
        ovf_evt && !baud_mode |=> ctrl_q.overflow_flag && stat_q.overflow)
        else $error("Overflow did not set the overflow flag.");

    a_ovf_flag_baud: assert property (
        $rose(ctrl_q.overflow_flag) |->
            $past(ovf_evt && !baud_mode) ||
            $past(wr_hit(bus_req, `T2CRB_ADDR_CTRL)))
        else $error("Overflow flag rose without a cause.");

    a_edge_flag_set: assert property (
        s_trig_fall_enabled |=> ctrl_q.external_edge_flag && stat_q.ext_edge)
        else $error("Enabled trigger fall did not set the edge flag.");

    a_reload_value: assert property (
        (ovf_reload || trig_reload) && no_cnt_wr |=> count_q == $past(rcap_q))
        else $error("Reload did not load the reload word.");

    a_capture_value: assert property (
        trig_capture && !ovf_evt |=> rcap_q == $past(count_q))
        else $error("Capture did not copy the count.");

    a_stop_holds: assert property (
        !ctrl_q.run_control && !trig_reload && no_cnt_wr |=> $stable(count_q))
        else $error("Count moved while the timer was off.");

    a_timer_step: assert property (
        cnt_step && !ovf_evt && !trig_reload && no_cnt_wr
            |=> count_q == $past(count_q) + 16'h0001)
        else $error("Count did not advance by one on a tick.");

    a_pin_event: assert property (
        s_count_fall |-> cnt_fall ##1 !cnt_fall)
        else $error("Count pin fall gave no single event.");

    a_baud_pulse: assert property (
        ovf_evt && baud_mode |=> baud_ovf_q ##1 (!baud_ovf_q || $past(ovf_evt)))
        else $error("Baud overflow pulse missing.");

    a_reset_zero: assert property (
        $past(rst) |-> ctrl_q == t2crb_ctrl_t'(`T2CRB_CTRL_RESET))
        else $error("Control register not zero after reset.");

    a_irq_level: assert property (
        |(stat_q & en_q) |-> irq_q)
        else $error("Interrupt low while an enabled status bit is set.");

    a_baud_no_flag: assert property (
        ovf_evt && baud_mode && !ctrl_q.overflow_flag && no_ctrl_wr
            |=> !ctrl_q.overflow_flag)
        else $error("Overflow flag set in baud-rate mode.");

    a_baud_no_stat: assert property (
        ovf_evt && baud_mode && !stat_q.overflow
            |=> !stat_q.overflow)
        else $error("Overflow status set in baud-rate mode.");

    a_rx_sel_copy: assert property (
        no_ctrl_wr
            |=> rx_clock_sel_q == $past(ctrl_q.rx_clock_select))
        else $error("Receive clock select output differs from control bit.");

    a_tx_sel_copy: assert property (
        no_ctrl_wr
            |=> tx_clock_sel_q == $past(ctrl_q.tx_clock_select))
        else $error("Transmit clock select output differs from control bit.");

    a_no_baud_pulse: assert property (
        !baud_mode || !ovf_evt
            |=> !baud_ovf_q)
        else $error("Baud pulse outside a baud-rate overflow.");

    a_trig_ignored: assert property (
        trg_fall && !ctrl_q.trigger_enable && !ctrl_q.external_edge_flag && no_ctrl_wr
            |=> !ctrl_q.external_edge_flag)
        else $error("Disabled trigger fall set the edge flag.");

    a_baud_no_capture: assert property (
        trig_evt && baud_mode && no_rcap_wr
            |=> $stable(rcap_q))
        else $error("Trigger changed the reload word in baud-rate mode.");

    a_baud_trig_hold: assert property (
        trig_evt && baud_mode && !cnt_step && no_cnt_wr
            |=> $stable(count_q))
        else $error("Trigger reloaded the count in baud-rate mode.");

    a_div_range: assert property (
        div_q <= DIV_LAST)
        else $error("Tick divider ran past its last count.");

    a_capture_wrap: assert property (
        ovf_evt && !baud_mode && ctrl_q.capture_select && no_cnt_wr
            |=> count_q == `T2CRB_WORD_RESET)
        else $error("Capture-mode overflow did not wrap the count to zero.");

    a_irq_masked: assert property (
        !(stat_q.overflow && en_q.overflow) && !(stat_q.ext_edge && en_q.ext_edge)
            |-> !irq_q)
        else $error("Interrupt high with no enabled status bit set.");

    a_src_pin_only: assert property (
        ctrl_q.run_control && ctrl_q.count_source_select && !cnt_fall
            && !trig_reload && no_cnt_wr |=> $stable(count_q))
        else $error("Count moved with no count pin fall.");

    a_run_flag_hold: assert property (
        !ctrl_q.run_control && !ctrl_q.overflow_flag && no_ctrl_wr
            |=> !ctrl_q.overflow_flag)
        else $error("Overflow flag set while the timer was off.");

endmodule : t2crb_top
`default_nettype wire

//--- src/t2crb_defs.svh
// Register offsets, reset values and tick divider for the timer block.
// Assumes the 8-bit register port of the surrounding core.
`ifndef T2CRB_DEFS_SVH
`define T2CRB_DEFS_SVH
`define T2CRB_ADDR_CTRL     8'hC8
`define T2CRB_ADDR_RCAP_LO  8'hCA
`define T2CRB_ADDR_RCAP_HI  8'hCB
`define T2CRB_ADDR_CNT_LO   8'hCC
`define T2CRB_ADDR_CNT_HI   8'hCD
`define T2CRB_ADDR_IRQ_STAT 8'hD0
`define T2CRB_ADDR_IRQ_CLR  8'hD1
`define T2CRB_ADDR_IRQ_EN   8'hD2
`define T2CRB_CTRL_RESET    8'h00
`define T2CRB_WORD_RESET    16'h0000
`define T2CRB_WORD_MAX      16'hFFFF
`define T2CRB_WORD_ONE      16'h0001
`define T2CRB_IRQ_RESET     2'h0
`define T2CRB_BYTE_ZERO     8'h00
`define T2CRB_SYNC_IDLE     2'h3
`define T2CRB_CLK_DIV       1
`endif

//--- src/t2crb_pkg.sv
// Types shared by the timer block: control layout, bus request, events.
// Assumes nothing of its surroundings.
package t2crb_pkg;

    typedef struct packed {
        logic overflow_flag;
        logic external_edge_flag;
        logic rx_clock_select;
        logic tx_clock_select;
        logic trigger_enable;
        logic run_control;
        logic count_source_select;
        logic capture_select;
    } t2crb_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } t2crb_bus_req_t;

    typedef struct packed {
        logic ext_edge;
        logic overflow;
    } t2crb_irq_t;

endpackage : t2crb_pkg

//--- verification/t2crb_pin_model.sv
// Far-side model: drives the count and trigger pins, counts baud pulses.
// Assumes pins idle high and the serial side only counts overflow pulses.
`timescale 1ns/1ns
`default_nettype none
module t2crb_pin_model (
    input  wire logic ref_clk,
    input  wire logic baud_ovf_q,
    output var  logic count_pin,
    output var  logic trigger_pin,
    output var  int   baud_seen
);
    initial begin
        count_pin   = 1'b1;
        trigger_pin = 1'b1;
        baud_seen   = 0;
    end

    always @(posedge ref_clk) begin
        if (baud_ovf_q === 1'b1) begin
            baud_seen <= baud_seen + 1;
        end
    end

    // Each level is held several cycles so the two-flop sampler sees it.
    task automatic fall(input bit trig, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            if (trig) begin
                trigger_pin <= 1'b0;
            end else begin
                count_pin <= 1'b0;
            end
            repeat (4) @(posedge ref_clk);
            trigger_pin <= 1'b1;
            count_pin   <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
    endtask : fall
endmodule : t2crb_pin_model
`default_nettype wire

//--- verification/t2crb_top_test.sv
// Self-checking bench for the timer block: registers, modes, pins, interrupt.
// Assumes the pin model drives both pins and counts baud pulses.
`timescale 1ns/1ns
`default_nettype none
`include "t2crb_defs.svh"
module t2crb_top_test
    import t2crb_pkg::*;
;
    logic           ref_clk;
    logic           rst;
    t2crb_bus_req_t bus_req;
    logic [7:0]     rd_data_q;
    logic           count_pin;
    logic           trigger_pin;
    logic           baud_ovf_q;
    logic           rx_clock_sel_q;
    logic           tx_clock_sel_q;
    logic           irq_q;
    int             baud_seen;
    int             miscompares = 0;
    int             checks_done = 0;
    int             cycles      = 0;
    integer         seed        = 32'h022CA603;
    logic [7:0]     rv;
    logic [7:0]     m;
    logic [7:0]     d;
    logic [7:0]     a;
    logic [15:0]    cv;
    logic [15:0]    rw;
    logic [15:0]    er;
    logic [15:0]    ec;
    logic           baud;
    int             b0;
    logic [7:0]     rst_addrs [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD0};
    logic [7:0]     ovf_modes [6] = '{8'h04, 8'h05, 8'h14, 8'h24, 8'h34, 8'h35};
    logic [7:0]     trg_modes [4] = '{8'h09, 8'h08, 8'h01, 8'h3C};

    t2crb_top dut (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .bus_req        (bus_req),
        .rd_data_q      (rd_data_q),
        .count_pin      (count_pin),
        .trigger_pin    (trigger_pin),
        .baud_ovf_q     (baud_ovf_q),
        .rx_clock_sel_q (rx_clock_sel_q),
        .tx_clock_sel_q (tx_clock_sel_q),
        .irq_q          (irq_q)
    );

    t2crb_pin_model pins (
        .ref_clk     (ref_clk),
        .baud_ovf_q  (baud_ovf_q),
        .count_pin   (count_pin),
        .trigger_pin (trigger_pin),
        .baud_seen   (baud_seen)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    // Expected control byte after an overflow (kind 0) or a trigger fall (kind 1).
    function automatic logic [7:0] exp_ctrl(input logic [7:0] c, input bit kind);
        if (!kind && !(c[5] | c[4])) begin
            return c | 8'h80;
        end
        return (kind && c[3]) ? (c | 8'h40) : c;
    endfunction : exp_ctrl

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge ref_clk);
        bus_req <= '{addr: ad, wdata: dt, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // The read data stand only in the cycle after the strobe.
    task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge ref_clk);
        bus_req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(rd_data_q, exp);
    endtask : rchk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        bus_req = '0;
        rst     = 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rst_addrs[i]) rchk(rst_addrs[i], 8'h00);
        for (int i = 0; i < 8; i++) begin
            a = 8'hCA + 8'(i % 4);
            d = 8'($random(seed));
            wr(a, d);
            rchk(a, d);
        end
        rchk(8'hE0, 8'h00);
        $display("test done: registers");
        foreach (ovf_modes[i]) begin
            m    = ovf_modes[i];
            baud = m[5] | m[4];
            d    = 8'($random(seed));
            wr(8'hCA, 8'h00);
            wr(8'hCB, d);
            wr(8'hCC, 8'hFE);
            wr(8'hCD, 8'hFF);
            wr(8'hD1, 8'h03);
            wr(8'hD2, 8'h01);
            b0 = baud_seen;
            wr(8'hC8, m);
            repeat (20) @(posedge ref_clk);
            chk({6'h00, rx_clock_sel_q, tx_clock_sel_q}, {6'h00, m[5:4]});
            chk(8'(baud_seen - b0), {7'h00, baud});
            chk({7'h00, irq_q}, {7'h00, !baud});
            rchk(8'hC8, exp_ctrl(m, 1'b0));
            rchk(8'hD0, {7'h00, !baud});
            wr(8'hC8, 8'h00);
            rchk(8'hCD, (m[0] && !baud) ? 8'h00 : d);
            $display("test done: overflow mode %h", m);
        end
        foreach (trg_modes[i]) begin
            m  = trg_modes[i];
            cv = 16'($random(seed));
            rw = 16'($random(seed));
            er = (m == 8'h09) ? cv : rw;
            ec = (m == 8'h08) ? rw : cv;
            wr(8'hCA, rw[7:0]);
            wr(8'hCB, rw[15:8]);
            wr(8'hCC, cv[7:0]);
            wr(8'hCD, cv[15:8]);
            wr(8'hD1, 8'h03);
            wr(8'hD2, 8'h02);
            wr(8'hC8, m);
            pins.fall(1'b1, 1);
            chk({7'h00, irq_q}, {7'h00, m[3]});
            rchk(8'hC8, exp_ctrl(m, 1'b1));
            if (!m[2]) begin
                rchk(8'hCA, er[7:0]);
                rchk(8'hCB, er[15:8]);
                rchk(8'hCC, ec[7:0]);
                rchk(8'hCD, ec[15:8]);
            end
            $display("test done: trigger mode %h", m);
        end
        wr(8'hC8, 8'h00);
        rchk(8'hD2, 8'h02);
        wr(8'hD2, 8'h00);
        rchk(8'hD0, 8'h02);
        chk({7'h00, irq_q}, 8'h00);
        wr(8'hD1, 8'h02);
        wr(8'hD0, 8'h03);
        rchk(8'hD0, 8'h00);
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        wr(8'hC8, 8'h06);
        pins.fall(1'b0, 5);
        wr(8'hC8, 8'h02);
        pins.fall(1'b0, 3);
        rchk(8'hCC, 8'h05);
        rchk(8'hCD, 8'h00);
        $display("test done: pin counting");
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rchk(8'hC8, 8'h00);
        rchk(8'hCC, 8'h00);
        $display("test done: reset in mid-run");
        finish_test();
    end
endmodule : t2crb_top_test
`default_nettype wire
